// file: hw/pio_decode_regs.vh
// Register indices, field positions, reset values and I/O port addresses of the port decoder
`ifndef PIO_DECODE_REGS_VH
`define PIO_DECODE_REGS_VH

// Host I/O addresses (10-bit low address, upper bits must be zero)
`define PIO_ADDR_INDEX_PORT   10'h022
`define PIO_ADDR_DATA_PORT    10'h023
`define PIO_ADDR_POS_ID_HIGH  10'h101

// Register indices written to the index port
`define PIO_IDX_PORT1_SETUP   8'h83
`define PIO_IDX_PORT1_CMP_LO  8'h84
`define PIO_IDX_PORT2_SETUP   8'h85
`define PIO_IDX_PORT2_CMP_LO  8'h86
`define PIO_IDX_SYS_ID_UPPER  8'h87

// Setup register field positions
`define PIO_SETUP_ADDR8       0
`define PIO_SETUP_ADDR9       1
`define PIO_SETUP_UPPER_SEL   2
`define PIO_SETUP_WR_QUAL     3
`define PIO_SETUP_RD_QUAL     4
`define PIO_SETUP_MASK_LSB    5
`define PIO_SETUP_MASK_MSB    7

// Reset values
`define PIO_RST_SETUP         8'h00
`define PIO_RST_CMP_LO        8'h00
`define PIO_RST_INDEX         8'h00
`define PIO_RST_UNMAPPED_RD   8'h00

// Synchroniser depth on every pin input
`define PIO_SYNC_STAGES       2

`endif

// file: hw/pio_sync.v
// Two-flop synchroniser for a bus of pin inputs, frozen while the clock enable is low
`timescale 1ns/1ps
`default_nettype none

module pio_sync #(
  parameter             WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             core_clk,
  input  wire             reset,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_reg;  // Metastability catcher, read only by stage2
  reg [WIDTH-1:0] stage2_reg;  // Settled copy for the logic

  // Two stages; resets to the inactive level so no strobe is seen at release
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end else if (clk_en) begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule

`default_nettype wire

// file: hw/pio_port_match.v
// Address and strobe compare for one programmable port select
`timescale 1ns/1ps
`default_nettype none
`include "pio_decode_regs.vh"

module pio_port_match (
  input  wire [7:0] setup,
  input  wire [7:0] compare_low,
  input  wire [9:0] io_addr_low,
  input  wire       onboard_io_n,
  input  wire       upper_addr_match_n,
  input  wire       io_write_strobe_n,
  input  wire       io_read_strobe_n,
  output wire       match
);

  // Mask pattern to don't-care vector for address bits 2..0.
  // Each pattern bit masks one address bit, so 001 frees bit 1 and 111 frees all three.
  function [2:0] pio_mask_decode;
    input [2:0] pattern;
    begin
      pio_mask_decode = {pattern[2], pattern[0], pattern[1]};  // [R7]
    end
  endfunction

  wire [9:0] cmp_addr;     // Full 10-bit compare value
  wire [9:0] care;         // One where the address bit takes part
  wire       low_hit;      // Unmasked low bits equal
  wire       upper_hit;    // Upper range qualifier present
  wire       wr_ok;        // Write qualification met
  wire       rd_ok;        // Read qualification met

  assign cmp_addr = {setup[`PIO_SETUP_ADDR9], setup[`PIO_SETUP_ADDR8], compare_low};
  assign care     = {7'h7F,
                     ~pio_mask_decode(setup[`PIO_SETUP_MASK_MSB:`PIO_SETUP_MASK_LSB])};
  assign low_hit  = ((io_addr_low ^ cmp_addr) & care) == 10'h000;

  // Upper range: on-board strobe means bits 10..16 zero, else the external decode
  assign upper_hit = setup[`PIO_SETUP_UPPER_SEL] ? ~upper_addr_match_n  // [R2]
                                                 : ~onboard_io_n;       // [R1]

  // Strobe qualification; a clear bit leaves the strobe out of the decode
  assign wr_ok = ~setup[`PIO_SETUP_WR_QUAL] | ~io_write_strobe_n;  // [R3] [R4]
  assign rd_ok = ~setup[`PIO_SETUP_RD_QUAL] | ~io_read_strobe_n;   // [R5] [R6]

  // Every enabled condition together
  assign match = low_hit & upper_hit & wr_ok & rd_ok;  // [R16]

endmodule

`default_nettype wire

// file: hw/pio_io_decode.v
// Programmable I/O port select decoder with index/data register access
// Contract
// R1: Upper select 0: on-board strobe, 1K range
// R2: Upper select 1: external upper decode, 64K
// R3: Setup bit 3 set: select only during writes
// R4: Setup bit 3 clear: write strobe ignored
// R5: Setup bit 4 set: select only during reads
// R6: Setup bit 4 clear: read strobe ignored
// R7: Setup bits 7:5 mask address bits 0-2
// R8: Index 84H holds port 1 compare bits 0-7
// R9: Index 86H holds port 2 compare bits 0-7
// R10: Index 85H bits 0,1 are port 2 bits 8,9
// R11: Index at port 22H, data through port 23H
// R12: Index 87H holds system ID upper byte
// R13: Port 0101H returns ID only in setup mode
// R14: Index 83H bits 0,1 are port 1 bits 8,9
// R15: Software enters setup mode via port 94 bit 7; this block decodes no port 94 and takes setup mode from the system_setup_n pin
// R16: Select low only when all conditions met
`timescale 1ns/1ps
`default_nettype none
`include "pio_decode_regs.vh"

module pio_io_decode #(
  parameter [7:0] SYS_ID_UPPER_RESET = 8'h5A  // Arbitrary neutral value, set per system
) (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       clk_en,
  input  wire [9:0] io_addr_low,
  input  wire [6:0] io_addr_high,
  input  wire       io_write_strobe_n,
  input  wire       io_read_strobe_n,
  input  wire       onboard_io_n,
  input  wire       upper_addr_match_n,
  input  wire       system_setup_n,
  input  wire [7:0] io_data_in,
  output wire [7:0] io_data_out,
  output wire       io_data_oe,
  output wire       prog_port_select_1_n,
  output wire       prog_port_select_2_n
);

  // How the block keeps time. Every pin crosses two flops before any logic reads it,
  // so the logic sees the bus two edges late, and the registered outputs follow one
  // edge after that: a select or a read answer appears on the third edge after its
  // pins settle, and drops on the third edge after they let go. The lag is fixed, so
  // host timing only has to allow for it once.
  // Register writes are committed at the rising edge of the write strobe, using the
  // address and data held from the cycle before it. The host may therefore drop them
  // as the strobe rises without spoiling the write.
  // Limitation: address and data are synchronised bit by bit, so they must be stable
  // for the two sync cycles before a strobe moves, or the logic may see a mix of old
  // and new bits. For the same reason each strobe has to stay low, and then high, for
  // at least two core_clk cycles; a shorter pulse may be missed.
  // Clock enable low freezes every flop, synchronisers included; a strobe that comes
  // and goes entirely while it is low is lost, so the host must not run cycles then.
  // Trade-off: registered outputs cost one more edge of lag but can never glitch
  // while the compare logic settles, which matters for select lines.

  // Synchronised pin inputs
  wire [9:0] addr_low_s;      // Low address bits
  wire [6:0] addr_high_s;     // Upper address bits 10..16
  wire [7:0] data_s;          // Write data
  wire       wr_n_s;          // Write strobe, active low
  wire       rd_n_s;          // Read strobe, active low
  wire       onboard_n_s;     // On-board I/O strobe
  wire       upper_n_s;       // External upper decode
  wire       setup_n_s;       // System setup mode, active low

  // Pin inputs all cross into core_clk through two flops
  pio_sync #(
    .WIDTH     (10),
    .RESET_VAL (10'h000)
  ) u_sync_addr_low (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_in   (io_addr_low),
    .sync_out (addr_low_s)
  );

  // Address bits 10..16 and write data ride the same two-stage chain as the strobes
  pio_sync #(
    .WIDTH     (15),
    .RESET_VAL (15'h0000)
  ) u_sync_high_data (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_in   ({io_addr_high, io_data_in}),
    .sync_out ({addr_high_s, data_s})
  );

  // Active-low controls reset to their inactive level
  pio_sync #(
    .WIDTH     (5),
    .RESET_VAL (5'h1F)
  ) u_sync_ctrl (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_in   ({io_write_strobe_n, io_read_strobe_n, onboard_io_n,
                upper_addr_match_n, system_setup_n}),
    .sync_out ({wr_n_s, rd_n_s, onboard_n_s, upper_n_s, setup_n_s})
  );

  // Register file and access state
  reg  [7:0] index_reg;           // Latched register index
  reg  [7:0] port1_setup_reg;     // Port 1 setup
  reg  [7:0] port1_cmp_low_reg;   // Port 1 compare bits 0-7
  reg  [7:0] port2_setup_reg;     // Port 2 setup
  reg  [7:0] port2_cmp_low_reg;   // Port 2 compare bits 0-7
  reg  [7:0] sys_id_upper_reg;    // System ID upper byte
  reg        wr_n_prev_reg;       // Write strobe one cycle back
  reg  [9:0] addr_prev_reg;       // Address held from the previous cycle
  reg        high_zero_prev_reg;  // Upper address zero in the previous cycle
  reg  [7:0] data_prev_reg;       // Write data held from the previous cycle
  reg  [7:0] rd_data_reg;         // Read data driven to the bus
  reg        rd_oe_reg;           // Bus drive enable
  reg        sel1_n_reg;          // Port select 1 output
  reg        sel2_n_reg;          // Port select 2 output
  reg  [7:0] rd_data_next;        // Read data chosen this cycle
  reg        rd_oe_next;          // Drive enable chosen this cycle

  // Decode results, all taken from synced pins
  wire       high_zero;           // Bits 10..16 all zero
  wire       wr_done;             // End of a host write cycle
  wire       hit_index_wr;        // Write to the index port
  wire       hit_data_wr;         // Write to the data port
  wire       match1;              // Port 1 decode
  wire       match2;              // Port 2 decode

  assign high_zero = addr_high_s == 7'h00;

  // Host port decode shared by the write and read paths: the upper address bits must be
  // zero and the low ten bits must name the port exactly. One copy means a write and a
  // read of the same address can never be steered to different ports.
  function pio_host_port_hit;
    input       upper_zero;  // Address bits 10..16 were all zero
    input [9:0] addr;        // Low address bits as the logic sees them
    input [9:0] port;        // Host port to test against
    begin
      pio_host_port_hit = upper_zero & (addr == port);
    end
  endfunction

  // Writes take effect at the strobe's rising edge, using the address and data that
  // stood while it was low; the host may let them go as the strobe rises.
  assign wr_done      = wr_n_s & ~wr_n_prev_reg;
  assign hit_index_wr = wr_done & pio_host_port_hit(high_zero_prev_reg, addr_prev_reg,
                                                    `PIO_ADDR_INDEX_PORT);  // [R11]
  assign hit_data_wr  = wr_done & pio_host_port_hit(high_zero_prev_reg, addr_prev_reg,
                                                    `PIO_ADDR_DATA_PORT);   // [R11]

  // Pipeline of strobe history and held address/data
  // The held copies give a write the address and data of the last cycle in which
  // the strobe was still low, the last cycle the host is sure to keep them.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_n_prev_reg      <= 1'b1;
      addr_prev_reg      <= 10'h000;
      high_zero_prev_reg <= 1'b0;
      data_prev_reg      <= 8'h00;
    end else if (clk_en) begin
      wr_n_prev_reg      <= wr_n_s;
      addr_prev_reg      <= addr_low_s;
      high_zero_prev_reg <= high_zero;
      data_prev_reg      <= data_s;
    end
  end

  // Index latch and indexed register writes
  // An index write and a data write never fall in one cycle: they need different
  // addresses in the same held-address flop.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      index_reg         <= `PIO_RST_INDEX;
      port1_setup_reg   <= `PIO_RST_SETUP;
      port1_cmp_low_reg <= `PIO_RST_CMP_LO;
      port2_setup_reg   <= `PIO_RST_SETUP;
      port2_cmp_low_reg <= `PIO_RST_CMP_LO;
      sys_id_upper_reg  <= SYS_ID_UPPER_RESET;  // [R12]
    end else if (clk_en) begin
      if (hit_index_wr) begin
        index_reg <= data_prev_reg;  // [R11]
      end
      if (hit_data_wr) begin
        // Route the data port to the latched index; unknown indices drop the write
        case (index_reg)
          `PIO_IDX_PORT1_SETUP: begin
            port1_setup_reg <= data_prev_reg;  // [R14]
          end
          `PIO_IDX_PORT1_CMP_LO: begin
            port1_cmp_low_reg <= data_prev_reg;  // [R8]
          end
          `PIO_IDX_PORT2_SETUP: begin
            port2_setup_reg <= data_prev_reg;  // [R10]
          end
          `PIO_IDX_PORT2_CMP_LO: begin
            port2_cmp_low_reg <= data_prev_reg;  // [R9]
          end
          `PIO_IDX_SYS_ID_UPPER: begin
            sys_id_upper_reg <= data_prev_reg;  // [R12]
          end
          // Unknown index: no register changes and the index simply stays
          default: begin
            index_reg <= index_reg;
          end
        endcase
      end
    end
  end

  // Read path: choose what the host sees during a read strobe
  // Reads use the live synced pins rather than the held copy: a read has no commit
  // edge, and the drive must let go as soon as the strobe does.
  always @* begin
    rd_data_next = `PIO_RST_UNMAPPED_RD;
    rd_oe_next   = 1'b0;
    if (~rd_n_s) begin
      if (pio_host_port_hit(high_zero, addr_low_s, `PIO_ADDR_INDEX_PORT)) begin
        rd_data_next = index_reg;
        rd_oe_next   = 1'b1;
      end else if (pio_host_port_hit(high_zero, addr_low_s, `PIO_ADDR_DATA_PORT)) begin
        rd_oe_next = 1'b1;
        // Data port reads the register under the latched index
        case (index_reg)
          `PIO_IDX_PORT1_SETUP:  rd_data_next = port1_setup_reg;    // [R14]
          `PIO_IDX_PORT1_CMP_LO: rd_data_next = port1_cmp_low_reg;  // [R8]
          `PIO_IDX_PORT2_SETUP:  rd_data_next = port2_setup_reg;    // [R10]
          `PIO_IDX_PORT2_CMP_LO: rd_data_next = port2_cmp_low_reg;  // [R9]
          `PIO_IDX_SYS_ID_UPPER: rd_data_next = sys_id_upper_reg;   // [R12]
          default:               rd_data_next = `PIO_RST_UNMAPPED_RD;
        endcase
      end else if (pio_host_port_hit(high_zero, addr_low_s, `PIO_ADDR_POS_ID_HIGH) &&
                   ~setup_n_s) begin
        // Outside setup mode this address belongs to someone else, so stay off the bus
        rd_data_next = sys_id_upper_reg;  // [R13] [R15]
        rd_oe_next   = 1'b1;
      end
    end
  end

  // Registered bus drive
  // Enable and data share one edge, so the bus never sees the enable ahead of
  // valid data, nor stale data after the enable.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data_reg <= 8'h00;
      rd_oe_reg   <= 1'b0;
    end else if (clk_en) begin
      rd_data_reg <= rd_data_next;
      rd_oe_reg   <= rd_oe_next;  // [R13]
    end
  end

  assign io_data_out = rd_data_reg;
  assign io_data_oe  = rd_oe_reg;

  // Compare logic for the two programmable selects
  // Both units see the same synced bus and differ only in their register sets; they
  // are pure logic, so the select flops below alone set the output timing.
  pio_port_match u_match1 (
    .setup              (port1_setup_reg),
    .compare_low        (port1_cmp_low_reg),
    .io_addr_low        (addr_low_s),
    .onboard_io_n       (onboard_n_s),
    .upper_addr_match_n (upper_n_s),
    .io_write_strobe_n  (wr_n_s),
    .io_read_strobe_n   (rd_n_s),
    .match              (match1)
  );

  pio_port_match u_match2 (
    .setup              (port2_setup_reg),
    .compare_low        (port2_cmp_low_reg),
    .io_addr_low        (addr_low_s),
    .onboard_io_n       (onboard_n_s),
    .upper_addr_match_n (upper_n_s),
    .io_write_strobe_n  (wr_n_s),
    .io_read_strobe_n   (rd_n_s),
    .match              (match2)
  );

  // Selects come from flops so the pins never glitch on decode settling
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel1_n_reg <= 1'b1;
      sel2_n_reg <= 1'b1;
    end else if (clk_en) begin
      sel1_n_reg <= ~match1;  // [R16]
      sel2_n_reg <= ~match2;  // [R16]
    end
  end

  // Both selects idle high in reset, so no device is picked while the block starts
  assign prog_port_select_1_n = sel1_n_reg;
  assign prog_port_select_2_n = sel2_n_reg;

endmodule

`default_nettype wire

// file: verif/pio_io_decode_sva.sv
// Pin-level checks of the programmable port decoder
`timescale 1ns/1ps
`default_nettype none
`include "pio_decode_regs.vh"
module pio_decode_chk (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [9:0] io_addr_low,
  input wire logic [6:0] io_addr_high,
  input wire logic       io_read_strobe_n,
  input wire logic       onboard_io_n,
  input wire logic       upper_addr_match_n,
  input wire logic       system_setup_n,
  input wire logic [7:0] io_data_out,
  input wire logic       io_data_oe,
  input wire logic       prog_port_select_1_n,
  input wire logic       prog_port_select_2_n
);
  // All checks on the core clock, quiet while reset is high
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Addresses the decoder may answer on the data lines
  wire addr_ok = (io_addr_high == 7'h00) && ((io_addr_low == `PIO_ADDR_INDEX_PORT) ||
    (io_addr_low == `PIO_ADDR_DATA_PORT) || (io_addr_low == `PIO_ADDR_POS_ID_HIGH));
  // Read strobe seen idle for three samples
  sequence s_rd_idle;
    io_read_strobe_n [*3];
  endsequence
  // Drive three edges after a read at a legal port
  sequence s_read_seen;
    $past(!io_read_strobe_n, 3) && $past(addr_ok, 3);
  endsequence
  a_oe_needs_read: assert property (io_data_oe |-> s_read_seen)
    else $error("data driven without a legal read");
  a_oe_drops_late: assert property (s_rd_idle |=> !io_data_oe)
    else $error("data drive outlived the read");
  a_pos_setup_only: assert property (io_data_oe &&
    $past(io_addr_low == `PIO_ADDR_POS_ID_HIGH, 3) |-> $past(!system_setup_n, 3))
    else $error("identity port answered outside setup mode");
  a_sel1_board: assert property (!prog_port_select_1_n |->
    $past(!onboard_io_n || !upper_addr_match_n, 3))
    else $error("select 1 without board or upper decode");
  a_sel2_board: assert property (!prog_port_select_2_n |->
    $past(!onboard_io_n || !upper_addr_match_n, 3))
    else $error("select 2 without board or upper decode");
  a_read_data_stable: assert property (io_data_oe && $past(io_data_oe) |-> $stable(io_data_out))
    else $error("read data moved during a read");
  a_reset_idle: assert property ($fell(reset) |->
    prog_port_select_1_n && prog_port_select_2_n && !io_data_oe)
    else $error("outputs not idle after reset");
  a_oe_no_early: assert property ($past(io_read_strobe_n, 2) |-> !$rose(io_data_oe))
    else $error("data drive came too early");
endmodule
bind pio_io_decode pio_decode_chk u_chk (.core_clk(core_clk), .reset(reset),
  .io_addr_low(io_addr_low), .io_addr_high(io_addr_high), .io_read_strobe_n(io_read_strobe_n),
  .onboard_io_n(onboard_io_n), .upper_addr_match_n(upper_addr_match_n),
  .system_setup_n(system_setup_n), .io_data_out(io_data_out), .io_data_oe(io_data_oe),
  .prog_port_select_1_n(prog_port_select_1_n), .prog_port_select_2_n(prog_port_select_2_n));
`default_nettype wire

// file: verif/pio_host_bfm.sv
// Host I/O bus model that drives the decoder's pins
`timescale 1ns/1ps
`default_nettype none
module pio_host_bfm (
  input  wire logic       core_clk,
  input  wire logic [7:0] io_data_out,
  input  wire logic       io_data_oe,
  output var  logic [9:0] io_addr_low,
  output var  logic [6:0] io_addr_high,
  output var  logic       io_write_strobe_n,
  output var  logic       io_read_strobe_n,
  output var  logic       onboard_io_n,
  output var  logic       upper_addr_match_n,
  output var  logic       system_setup_n,
  output var  logic [7:0] io_data_in
);
  // Idle bus at time zero: strobes off, no decode, normal mode
  initial begin
    io_addr_low = 10'h000;
    io_addr_high = 7'h00;
    {onboard_io_n, upper_addr_match_n, io_write_strobe_n, io_read_strobe_n} = 4'hF;
    system_setup_n = 1'b1;
    io_data_in = 8'hA5;
  end
  // Pins always move one nanosecond after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Address and data settle three cycles before the strobe, held after it
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    {io_addr_high, io_addr_low} = a;
    io_data_in = d;
    cyc(3);
    io_write_strobe_n = 1'b0;
    cyc(3);
    io_write_strobe_n = 1'b1;
    cyc(1);
    io_data_in = ~d; // Released lines do not keep the old value
    cyc(3);
  endtask
  // Read sampled once the synchroniser and output register have passed
  task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic oe);
    {io_addr_high, io_addr_low} = a;
    cyc(3);
    io_read_strobe_n = 1'b0;
    cyc(4);
    d = io_data_out;
    oe = io_data_oe;
    io_read_strobe_n = 1'b1;
    cyc(4);
  endtask
  // Plain bus cycle with board, upper decode and strobe levels q
  task automatic pins(input logic [9:0] a, input logic [3:0] q);
    io_addr_low = a;
    {onboard_io_n, upper_addr_match_n, io_write_strobe_n, io_read_strobe_n} = q;
    cyc(4);
  endtask
  // Setup mode entered by clearing the mode bit, left by setting it
  task automatic setup_mode(input logic n);
    system_setup_n = n;
    cyc(1);
  endtask
endmodule
`default_nettype wire

// file: verif/test_programmable_io_port_decode.sv
// Self-checking bench of the programmable port decoder
`timescale 1ns/1ps
`default_nettype none
`include "pio_decode_regs.vh"
module test_programmable_io_port_decode;
  localparam logic [7:0]  ID_RST = 8'h3C; // Arbitrary identity value
  localparam logic [16:0] IDXP = {7'h00, `PIO_ADDR_INDEX_PORT};
  localparam logic [16:0] DATP = {7'h00, `PIO_ADDR_DATA_PORT};
  localparam logic [16:0] POSP = {7'h00, `PIO_ADDR_POS_ID_HIGH};
  logic       core_clk = 1'b0;
  logic       reset    = 1'b1;
  logic       clk_en   = 1'b1; // Dropped once to test the freeze
  wire  [9:0] io_addr_low;
  wire  [6:0] io_addr_high;
  wire        wr_n, rd_n, onb_n, up_n, setup_n, io_data_oe, sel1_n, sel2_n;
  wire  [7:0] io_data_in, io_data_out;
  int         num_errors = 0;
  int         samples_checked = 0;
  logic [7:0] d;
  logic       oe;
  logic [39:0] r;
  // Rows: port, setup, compare, address, {board,upper,wr,rd}, select level
  logic [39:0] rows [16] = '{
    40'h0_02_F4_2F4_7_0, 40'h0_02_F4_2F4_B_1, 40'h0_06_F4_2F4_B_0, 40'h1_06_F4_2F4_7_1,
    40'h0_0A_F4_2F4_7_1, 40'h1_0A_F4_2F4_5_0, 40'h0_02_F4_2F4_4_0, 40'h0_12_F4_2F4_7_1,
    40'h1_12_F4_2F4_6_0, 40'h0_22_F4_2F6_7_0, 40'h0_22_F4_2F5_7_1, 40'h1_E2_F4_2F3_7_0,
    40'h1_E2_F4_2FB_7_1, 40'h0_01_F4_1F4_7_0, 40'h1_01_3C_13C_7_0, 40'h1_02_3C_03C_7_1};
  always #2.5 core_clk = ~core_clk;
  pio_io_decode #(.SYS_ID_UPPER_RESET(ID_RST)) u_dut (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .io_addr_low(io_addr_low), .io_addr_high(io_addr_high),
    .io_write_strobe_n(wr_n), .io_read_strobe_n(rd_n), .onboard_io_n(onb_n),
    .upper_addr_match_n(up_n), .system_setup_n(setup_n), .io_data_in(io_data_in),
    .io_data_out(io_data_out), .io_data_oe(io_data_oe),
    .prog_port_select_1_n(sel1_n), .prog_port_select_2_n(sel2_n));
  pio_host_bfm u_host (.core_clk(core_clk), .io_data_out(io_data_out), .io_data_oe(io_data_oe),
    .io_addr_low(io_addr_low), .io_addr_high(io_addr_high), .io_write_strobe_n(wr_n),
    .io_read_strobe_n(rd_n), .onboard_io_n(onb_n), .upper_addr_match_n(up_n),
    .system_setup_n(setup_n), .io_data_in(io_data_in));
  // One compare, counted, reported at once on a miss
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Register write and read through the index/data pair
  task automatic setw(input logic [7:0] i, input logic [7:0] v);
    u_host.wr(IDXP, i);
    u_host.wr(DATP, v);
  endtask
  task automatic rreg(input logic [7:0] i, output logic [7:0] v);
    u_host.wr(IDXP, i);
    u_host.rd(DATP, v, oe);
  endtask
  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Guard against a hung run
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    // Table cases: program one port, then drive a bus cycle at it
    for (int i = 0; i < 16; i++) begin
      r = rows[i];
      setw(`PIO_IDX_PORT1_SETUP + {6'h00, r[36], 1'b0}, r[35:28]);
      setw(`PIO_IDX_PORT1_CMP_LO + {6'h00, r[36], 1'b0}, r[27:20]);
      u_host.pins(r[17:8], r[7:4]);
      check({7'h00, r[36] ? sel2_n : sel1_n}, {7'h00, r[0]});
      u_host.pins(r[17:8], 4'hF);
    end
    // Clock enable low freezes the decode: port 1 (1F4H, on-board) stays off until it returns
    clk_en = 1'b0;
    u_host.pins(10'h1F4, 4'h7);
    check({7'h00, sel1_n}, 8'h01);
    clk_en = 1'b1;
    u_host.cyc(4);
    check({7'h00, sel1_n}, 8'h00);
    // Second reset mid-run with select 1 active: outputs idle at once, registers to defaults
    reset = 1'b1;
    u_host.cyc(1);
    check({6'h00, sel2_n, sel1_n, io_data_oe}, 8'h06);
    u_host.pins(10'h1F4, 4'hF);
    u_host.cyc(5);
    reset = 1'b0;
    for (int j = 0; j < 5; j++) begin
      rreg(`PIO_IDX_PORT1_SETUP + j[7:0], d);
      check(d, (j == 4) ? ID_RST : 8'h00);
    end
    // Identity byte is writable, seen at the POS port in setup mode only
    setw(`PIO_IDX_SYS_ID_UPPER, 8'hC3);
    rreg(`PIO_IDX_SYS_ID_UPPER, d);
    check(d, 8'hC3);
    u_host.setup_mode(1'b0);
    u_host.rd(POSP, d, oe);
    check(d, 8'hC3);
    check({7'h00, oe}, 8'h01);
    u_host.setup_mode(1'b1);
    u_host.rd(POSP, d, oe);
    check({7'h00, oe}, 8'h00);
    // Unknown index reads zero and a write there lands nowhere
    setw(8'h90, 8'h55);
    u_host.rd(DATP, d, oe);
    check(d, 8'h00);
    check({7'h00, oe}, 8'h01);
    u_host.rd(IDXP, d, oe);
    check(d, 8'h90);
    rreg(`PIO_IDX_PORT1_CMP_LO, d);
    check(d, 8'h00);
    // Nonzero upper address is not the data port
    u_host.rd(17'h00423, d, oe);
    check({7'h00, oe}, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire
